/* core/usrt_defs.svh */
// Register offsets, field positions, reset values and timing counts of the serial core
`ifndef USRT_DEFS_SVH
`define USRT_DEFS_SVH

// Register byte offsets on the APB bus
`define USRT_OFF_DATA 8'h00
`define USRT_OFF_CSA 8'h04
`define USRT_OFF_CSB 8'h08
`define USRT_OFF_CSC 8'h0c
`define USRT_OFF_BAUD 8'h10

// control_status_a fields
`define USRT_A_RXC 7
`define USRT_A_TXC 6
`define USRT_A_UDRE 5
`define USRT_A_PERR 2
`define USRT_A_DBL 1

// control_status_b fields
`define USRT_B_RXCIE 7
`define USRT_B_TXCIE 6
`define USRT_B_UDRIE 5
`define USRT_B_RXEN 4
`define USRT_B_TXEN 3
`define USRT_B_SZ2 2
`define USRT_B_RXB8 1
`define USRT_B_TXB8 0

// control_status_c fields
`define USRT_C_SYNC 6
`define USRT_C_PEN 5
`define USRT_C_PODD 4
`define USRT_C_STOP2 3
`define USRT_C_SZ_HI 2
`define USRT_C_SZ_LO 1

// Reset values
`define USRT_RST_B 8'h00
`define USRT_RST_C 8'h06
`define USRT_RST_BAUD 12'h000

// Character size codes and bit counts
`define USRT_SZ_NINE 3'd7
`define USRT_BITS_NINE 4'd9
`define USRT_BITS_MIN 4'd5
`define USRT_BITS_DFLT 4'd8

// Oversampling: last phase of a bit and middle of a bit, normal and double speed
`define USRT_OVS_NORM 4'd15
`define USRT_OVS_DBL 4'd7
`define USRT_MID_NORM 4'd7
`define USRT_MID_DBL 4'd3

`endif

/* core/usrt_pkg.sv */
// Types shared by the serial core: frame configuration and state machine codes
package usrt_pkg;

  // Frame format and clocking as software set it
  typedef struct packed {
    logic sync;
    logic dbl;
    logic par_en;
    logic par_odd;
    logic two_stop;
    logic [2:0] size;
  } usrt_cfg_t;

  // Transmitter states
  typedef enum logic [4:0] {
    USRT_TX_IDLE = 5'b00001,
    USRT_TX_START = 5'b00010,
    USRT_TX_DATA = 5'b00100,
    USRT_TX_PAR = 5'b01000,
    USRT_TX_STOP = 5'b10000
  } usrt_tx_state_t;

  // Receiver states
  typedef enum logic [4:0] {
    USRT_RX_IDLE = 5'b00001,
    USRT_RX_START = 5'b00010,
    USRT_RX_DATA = 5'b00100,
    USRT_RX_PAR = 5'b01000,
    USRT_RX_STOP = 5'b10000
  } usrt_rx_state_t;

endpackage : usrt_pkg

/* core/usrt_core.sv */
// Serial transmitter and receiver core with APB register access
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "usrt_defs.svh"

// What this block does
// - Parity is the XOR of the data bits, inverted for odd parity.
// - The parity bit sits after the last data bit, before the first stop bit.
// - While transmit is enabled the core drives the transmit pin.
// - In synchronous mode the serial clock pin clocks the transmitter.
// - Writing the data register loads the transmit buffer.
// - Buffer moves to the shifter when idle or right after the last stop bit.
// - A loaded shifter sends one whole frame at the selected bit rate.
// - Unused upper data bits are ignored for short characters.
// - Empty flag is high while the transmit buffer is empty.
// - Empty interrupt requests last while flag, enable and global enable are set.
// - Writing the data register clears the empty flag.
// - Transmit complete sets after a frame ends with the buffer empty.
// - Transmit complete clears on interrupt service or on writing one.
// - Transmit complete interrupt requests while flag and enables are set.
// - Parity enabled inserts the parity bit between data and stop bits.
// - Transmit disable waits for shifter and buffer to empty, then releases the pin.
// - Receive enable takes over the receive pin.
// - After a valid start bit each bit is sampled through the first stop bit.
// - The first stop bit moves the received character into the receive buffer.
// - Unused upper bits of a short received character read as zero.
// - Frame: low start, data LSB first, optional parity, one or two high stops.
// - The odd select bit picks even or odd parity for both directions.
// - Stop select picks one or two transmitted stop bits.
// - Receive complete is high while unread data sits in the receive buffer.
module usrt_core #(
  parameter int BAUD_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_pin,
  input wire logic xck_pin,
  input wire logic global_int_enable,
  input wire logic txc_int_ack,
  output logic txd_out,
  output logic txd_oe,
  output logic rxd_takeover,
  output logic irq_udre,
  output logic irq_txc,
  output logic irq_rxc
);
  import usrt_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Number of data bits for a size code
  function automatic logic [3:0] data_bits(input logic [2:0] code);
    if (code == `USRT_SZ_NINE) begin
      data_bits = `USRT_BITS_NINE;
    end else if (code[2]) begin
      data_bits = `USRT_BITS_DFLT;
    end else begin
      data_bits = `USRT_BITS_MIN + {2'b00, code[1:0]};
    end
  endfunction : data_bits

  // Keep only the character's own bits
  function automatic logic [8:0] char_mask(input logic [8:0] d, input logic [3:0] n);
    logic [8:0] m;
    m = 9'h1ff >> (`USRT_BITS_NINE - n);
    char_mask = d & m;
  endfunction : char_mask

  // Parity over the character bits
  function automatic logic par_of(input logic [8:0] d, input logic [3:0] n, input logic odd);
    par_of = (^char_mask(d, n)) ^ odd;
  endfunction : par_of

  // Mapped register address
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `USRT_OFF_DATA) || (a == `USRT_OFF_CSA) || (a == `USRT_OFF_CSB) ||
               (a == `USRT_OFF_CSC) || (a == `USRT_OFF_BAUD);
  endfunction : addr_hit

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] csb_reg;
  logic [7:0] csc_reg;
  logic dbl_reg;
  logic [BAUD_W-1:0] baud_reg;
  logic [BAUD_W-1:0] baud_cnt_reg;
  logic [31:0] prdata_reg;
  logic rxd_meta_reg;
  logic rxd_sync_reg;
  logic xck_meta_reg;
  logic xck_sync_reg;
  logic xck_prev_reg;
  usrt_cfg_t cfg;
  logic [3:0] nbits;
  logic apb_setup;
  logic apb_wr;
  logic apb_rd;
  logic data_wr;
  logic data_rd;
  logic baud_wr;
  logic base_tick;
  logic xck_rise;
  logic xck_fall;
  logic [3:0] bit_last;
  logic [3:0] bit_mid;
  // Transmitter
  usrt_tx_state_t tx_state_reg;
  logic [3:0] tx_phase_reg;
  logic [8:0] tx_shift_reg;
  logic [3:0] tx_cnt_reg;
  logic tx_par_reg;
  logic tx_stop_more_reg;
  logic tx_line_reg;
  logic [8:0] txbuf_reg;
  logic txbuf_full_reg;
  logic txc_reg;
  logic txen_eff_reg;
  logic tx_tick;
  logic tx_load;
  logic tx_done;
  // Receiver
  usrt_rx_state_t rx_state_reg;
  logic [3:0] rx_phase_reg;
  logic [8:0] rx_shift_reg;
  logic [3:0] rx_cnt_reg;
  logic rx_par_reg;
  logic [8:0] rxbuf_reg;
  logic rx_perr_reg;
  logic rxc_reg;
  logic rx_sample;
  logic rx_done;
  logic [8:0] rx_aligned;
  logic rxen;
  logic [31:0] rd_val;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration and decode

  // Frame format gathered from the control registers
  assign cfg = '{sync: csc_reg[`USRT_C_SYNC], dbl: dbl_reg, par_en: csc_reg[`USRT_C_PEN],
                 par_odd: csc_reg[`USRT_C_PODD], two_stop: csc_reg[`USRT_C_STOP2],
                 size: {csb_reg[`USRT_B_SZ2], csc_reg[`USRT_C_SZ_HI:`USRT_C_SZ_LO]}};
  assign nbits = data_bits(cfg.size);
  assign rxen = csb_reg[`USRT_B_RXEN];

  // APB phases and register strobes
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;
  assign data_wr = apb_wr & (paddr == `USRT_OFF_DATA);
  assign data_rd = apb_rd & (paddr == `USRT_OFF_DATA);
  assign baud_wr = apb_wr & (paddr == `USRT_OFF_BAUD);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit(paddr);
  assign prdata = prdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and clock edges

  // Two flops on each pin before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
      xck_meta_reg <= 1'b0;
      xck_sync_reg <= 1'b0;
      xck_prev_reg <= 1'b0;
    end else begin
      rxd_meta_reg <= rxd_pin;
      rxd_sync_reg <= rxd_meta_reg;
      xck_meta_reg <= xck_pin;
      xck_sync_reg <= xck_meta_reg;
      xck_prev_reg <= xck_sync_reg;
    end
  end

  // Serial clock edges: transmit changes on rise, receive samples on fall
  assign xck_rise = cfg.sync & xck_sync_reg & ~xck_prev_reg;
  assign xck_fall = cfg.sync & ~xck_sync_reg & xck_prev_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Baud divider

  // Down-counter reloads on zero or on a divisor write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_reg <= '0;
    end else if (baud_wr || baud_cnt_reg == '0) begin
      baud_cnt_reg <= baud_wr ? pwdata[BAUD_W-1:0] : baud_reg;
    end else begin
      baud_cnt_reg <= baud_cnt_reg - 1'b1;
    end
  end

  assign base_tick = ~cfg.sync & (baud_cnt_reg == '0);
  assign bit_last = cfg.dbl ? `USRT_OVS_DBL : `USRT_OVS_NORM;
  assign bit_mid = cfg.dbl ? `USRT_MID_DBL : `USRT_MID_NORM;

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  // Control registers and divisor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csb_reg <= `USRT_RST_B;
      csc_reg <= `USRT_RST_C;
      dbl_reg <= 1'b0;
      baud_reg <= `USRT_RST_BAUD;
    end else if (apb_wr) begin
      unique case (paddr)
        `USRT_OFF_CSA: dbl_reg <= pwdata[`USRT_A_DBL];
        `USRT_OFF_CSB: csb_reg <= pwdata[7:0] & ~(8'h01 << `USRT_B_RXB8);
        `USRT_OFF_CSC: csc_reg <= pwdata[7:0] & 8'h7f;
        `USRT_OFF_BAUD: baud_reg <= pwdata[BAUD_W-1:0];
        default: ;
      endcase
    end
  end

  // Read value; received ninth bit shows in control_status_b
  always_comb begin
    rd_val = '0;
    unique case (paddr)
      `USRT_OFF_DATA: rd_val[7:0] = rxbuf_reg[7:0];
      `USRT_OFF_CSA: begin
        rd_val[`USRT_A_RXC] = rxc_reg;
        rd_val[`USRT_A_TXC] = txc_reg;
        rd_val[`USRT_A_UDRE] = ~txbuf_full_reg;
        rd_val[`USRT_A_PERR] = rx_perr_reg;
        rd_val[`USRT_A_DBL] = dbl_reg;
      end
      `USRT_OFF_CSB: begin
        rd_val[7:0] = csb_reg;
        rd_val[`USRT_B_RXB8] = rxbuf_reg[8];
      end
      `USRT_OFF_CSC: rd_val[7:0] = csc_reg;
      `USRT_OFF_BAUD: rd_val[BAUD_W-1:0] = baud_reg;
      default: rd_val = '0;
    endcase
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (apb_setup && !pwrite) begin
      prdata_reg <= rd_val;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit buffer and flags

  // Bit period end for the transmitter
  assign tx_tick = cfg.sync ? xck_rise : (base_tick && tx_phase_reg == bit_last);
  assign tx_done = tx_tick && tx_state_reg == USRT_TX_STOP && !tx_stop_more_reg;
  assign tx_load = tx_tick && txbuf_full_reg && txen_eff_reg &&
                   (tx_state_reg == USRT_TX_IDLE || tx_done);

  // Buffer: a write wins over a load in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txbuf_reg <= '0;
      txbuf_full_reg <= 1'b0;
    end else if (data_wr) begin
      txbuf_reg <= {csb_reg[`USRT_B_TXB8], pwdata[7:0]};
      txbuf_full_reg <= 1'b1;
    end else if (tx_load) begin
      txbuf_full_reg <= 1'b0;
    end
  end

  // Transmit complete: set wins over either clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txc_reg <= 1'b0;
    end else if (tx_done && !txbuf_full_reg) begin
      txc_reg <= 1'b1;
    end else if (txc_int_ack || (apb_wr && paddr == `USRT_OFF_CSA && pwdata[`USRT_A_TXC])) begin
      txc_reg <= 1'b0;
    end
  end

  // Enable stays in force until shifter and buffer are empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txen_eff_reg <= 1'b0;
    end else if (csb_reg[`USRT_B_TXEN]) begin
      txen_eff_reg <= 1'b1;
    end else if (tx_state_reg == USRT_TX_IDLE && !txbuf_full_reg) begin
      txen_eff_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit shifter

  // Bit phase counter in async mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_phase_reg <= '0;
    end else if (base_tick) begin
      tx_phase_reg <= (tx_phase_reg == bit_last) ? 4'd0 : tx_phase_reg + 4'd1;
    end
  end

  // Frame sequencer: start, data LSB first, parity, stop bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= USRT_TX_IDLE;
      tx_shift_reg <= '0;
      tx_cnt_reg <= '0;
      tx_par_reg <= 1'b0;
      tx_stop_more_reg <= 1'b0;
      tx_line_reg <= 1'b1;
    end else if (tx_load) begin
      tx_shift_reg <= char_mask(txbuf_reg, nbits);
      tx_par_reg <= par_of(txbuf_reg, nbits, cfg.par_odd);
      tx_cnt_reg <= nbits - 4'd1;
      tx_line_reg <= 1'b0;
      tx_state_reg <= USRT_TX_START;
    end else if (tx_tick) begin
      unique case (tx_state_reg)
        USRT_TX_IDLE: tx_line_reg <= 1'b1;
        USRT_TX_START: begin
          tx_line_reg <= tx_shift_reg[0];
          tx_shift_reg <= tx_shift_reg >> 1;
          tx_state_reg <= USRT_TX_DATA;
        end
        USRT_TX_DATA: begin
          if (tx_cnt_reg == 4'd1 || tx_cnt_reg == 4'd0) begin
            if (tx_cnt_reg == 4'd1) begin
              tx_line_reg <= tx_shift_reg[0];
              tx_cnt_reg <= 4'd0;
            end else if (cfg.par_en) begin
              tx_line_reg <= tx_par_reg;
              tx_state_reg <= USRT_TX_PAR;
            end else begin
              tx_line_reg <= 1'b1;
              tx_stop_more_reg <= cfg.two_stop;
              tx_state_reg <= USRT_TX_STOP;
            end
          end else begin
            tx_line_reg <= tx_shift_reg[0];
            tx_shift_reg <= tx_shift_reg >> 1;
            tx_cnt_reg <= tx_cnt_reg - 4'd1;
          end
        end
        USRT_TX_PAR: begin
          tx_line_reg <= 1'b1;
          tx_stop_more_reg <= cfg.two_stop;
          tx_state_reg <= USRT_TX_STOP;
        end
        USRT_TX_STOP: begin
          if (tx_stop_more_reg) begin
            tx_stop_more_reg <= 1'b0;
          end else begin
            tx_state_reg <= USRT_TX_IDLE;
          end
        end
      endcase
    end
  end

  // Pin override while the transmitter is in force
  assign txd_oe = txen_eff_reg;
  assign txd_out = tx_line_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Receiver

  // Sample strobe: middle of the start bit, then once per bit period
  assign rx_sample = cfg.sync ? xck_fall :
                     (base_tick && rx_phase_reg == (rx_state_reg == USRT_RX_START ?
                                                    bit_mid : bit_last));
  assign rx_done = rx_sample && rx_state_reg == USRT_RX_STOP;
  assign rx_aligned = rx_shift_reg >> (`USRT_BITS_NINE - nbits);

  // Phase counter restarts at each sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_phase_reg <= '0;
    end else if (rx_state_reg == USRT_RX_IDLE || rx_sample) begin
      rx_phase_reg <= '0;
    end else if (base_tick) begin
      rx_phase_reg <= rx_phase_reg + 4'd1;
    end
  end

  // Frame receiver; disabling drops any frame in progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= USRT_RX_IDLE;
      rx_shift_reg <= '0;
      rx_cnt_reg <= '0;
      rx_par_reg <= 1'b0;
    end else if (!rxen) begin
      rx_state_reg <= USRT_RX_IDLE;
    end else begin
      unique case (rx_state_reg)
        USRT_RX_IDLE: begin
          if (!cfg.sync && !rxd_sync_reg) begin
            rx_state_reg <= USRT_RX_START;
          end else if (xck_fall && !rxd_sync_reg) begin
            rx_cnt_reg <= nbits - 4'd1;
            rx_state_reg <= USRT_RX_DATA;
          end
        end
        USRT_RX_START: begin
          if (rx_sample) begin
            rx_cnt_reg <= nbits - 4'd1;
            rx_state_reg <= rxd_sync_reg ? USRT_RX_IDLE : USRT_RX_DATA;
          end
        end
        USRT_RX_DATA: begin
          if (rx_sample) begin
            rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[8:1]};
            rx_cnt_reg <= rx_cnt_reg - 4'd1;
            if (rx_cnt_reg == 4'd0) begin
              rx_state_reg <= cfg.par_en ? USRT_RX_PAR : USRT_RX_STOP;
            end
          end
        end
        USRT_RX_PAR: begin
          if (rx_sample) begin
            rx_par_reg <= rxd_sync_reg;
            rx_state_reg <= USRT_RX_STOP;
          end
        end
        USRT_RX_STOP: begin
          if (rx_sample) begin
            rx_state_reg <= USRT_RX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive buffer: flush on disable, a new frame wins over a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxbuf_reg <= '0;
      rx_perr_reg <= 1'b0;
      rxc_reg <= 1'b0;
    end else if (!rxen) begin
      rxc_reg <= 1'b0;
      rx_perr_reg <= 1'b0;
    end else if (rx_done) begin
      rxbuf_reg <= char_mask(rx_aligned, nbits);
      rx_perr_reg <= cfg.par_en & (rx_par_reg ^ par_of(rx_aligned, nbits, cfg.par_odd));
      rxc_reg <= 1'b1;
    end else if (data_rd) begin
      rxc_reg <= 1'b0;
    end
  end

  assign rxd_takeover = rxen;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt requests

  // Level requests gated by their enables and the global enable
  assign irq_udre = global_int_enable & csb_reg[`USRT_B_UDRIE] & ~txbuf_full_reg;
  assign irq_txc = global_int_enable & csb_reg[`USRT_B_TXCIE] & txc_reg;
  assign irq_rxc = global_int_enable & csb_reg[`USRT_B_RXCIE] & rxc_reg;

endmodule : usrt_core

/* bench/usrt_core_monitor.sv */
// Port checker for the serial core
`timescale 1ns/1ps
`include "usrt_defs.svh"
module usrt_core_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic global_int_enable,
  input wire logic txc_int_ack,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic rxd_takeover,
  input wire logic irq_udre,
  input wire logic irq_txc,
  input wire logic irq_rxc
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase of an APB transfer
  wire acc = psel && penable;
  a_irq_gate: assert property (!global_int_enable |-> !(irq_udre || irq_txc || irq_rxc))
    else $error("irq while globally disabled");
  a_start_owned: assert property ($fell(txd_out) |-> txd_oe)
    else $error("start bit on released pin");
  a_start_len: assert property ($fell(txd_out) |=> !txd_out [*7])
    else $error("start bit too short");
  a_txc_idle: assert property ($rose(irq_txc) |-> txd_out)
    else $error("complete before frame end");
  a_txc_ack: assert property (txc_int_ack |=> !irq_txc)
    else $error("complete kept after service");
  a_txc_w1c: assert property (acc && pwrite && paddr == `USRT_OFF_CSA && pwdata[`USRT_A_TXC]
    |=> !irq_txc)
    else $error("complete kept after write one");
  a_rxc_read: assert property (acc && !pwrite && paddr == `USRT_OFF_DATA |=> !irq_rxc)
    else $error("receive flag kept after read");
  a_rx_owner: assert property (acc && pwrite && paddr == `USRT_OFF_CSB |=>
    rxd_takeover == $past(pwdata[`USRT_B_RXEN]))
    else $error("receive pin ownership wrong");
  // Main scenarios reached
  c_txc: cover property ($rose(irq_txc));
  c_rxc: cover property ($rose(irq_rxc));
  c_release: cover property ($fell(txd_oe));
endmodule : usrt_core_monitor

bind usrt_core usrt_core_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .global_int_enable(global_int_enable), .txc_int_ack(txc_int_ack), .txd_out(txd_out),
  .txd_oe(txd_oe), .rxd_takeover(rxd_takeover), .irq_udre(irq_udre), .irq_txc(irq_txc),
  .irq_rxc(irq_rxc));

/* bench/usrt_station.sv */
// Remote serial station: sends frames and captures transmitted ones
`timescale 1ns/1ps
module usrt_station (
  input wire logic pclk,
  input wire logic txd_out,
  input wire logic txd_oe,
  output logic rxd_pin
);
  int bit_cyc = 16;
  // Line idles high, as with a pull-up
  initial rxd_pin = 1'b1;
  // Low start, bits LSB first, high stops
  task automatic send(input logic [9:0] v, input int n, input int ns);
    @(posedge pclk);
    rxd_pin <= 1'b0;
    repeat (bit_cyc) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      rxd_pin <= v[i];
      repeat (bit_cyc) @(posedge pclk);
    end
    rxd_pin <= 1'b1;
    repeat (ns * bit_cyc) @(posedge pclk);
  endtask : send
  // Samples a frame at mid bit; t counts the wait for its start
  task automatic grab(output logic [9:0] v, input int n, output logic ok, output int t);
    v = '0;
    for (t = 0; t < 5000 && txd_out !== 1'b0; t++) @(posedge pclk);
    repeat (bit_cyc / 2) @(posedge pclk);
    ok = txd_out === 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (bit_cyc) @(posedge pclk);
      v[i] = txd_out;
    end
    repeat (bit_cyc) @(posedge pclk);
    ok = ok && txd_out === 1'b1 && txd_oe === 1'b1 && t < 5000;
  endtask : grab
endmodule : usrt_station

/* bench/testbench.sv */
// Self-checking bench for the serial core
`timescale 1ns/1ps
`include "usrt_defs.svh"
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, gie = 0, ack = 0, serial_clock_pin = 0;
  logic [7:0] paddr = '0, bcsb;
  logic [31:0] pwdata = '0, prdata, q, fmt;
  logic pready, pslverr, rxd_pin, txd_out, txd_oe, take, iu, it, ir, se, ok, ok2;
  logic [8:0] da, db, rv;
  logic [9:0] ga, gb;
  int n_fail = 0, check_count = 0, seed = 32'h36b0376f, nb, n, t1, t2, e;
  always #12.5 pclk = ~pclk;
  usrt_core u_usrt_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_pin(rxd_pin), .xck_pin(serial_clock_pin), .global_int_enable(gie),
    .txc_int_ack(ack), .txd_out(txd_out), .txd_oe(txd_oe), .rxd_takeover(take),
    .irq_udre(iu), .irq_txc(it), .irq_rxc(ir));
  usrt_station u_stn (.pclk(pclk), .txd_out(txd_out), .txd_oe(txd_oe), .rxd_pin(rxd_pin));
  //////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    check_count++;
    if (g !== x) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask : chk
  // One APB transfer; read data lands in q
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Expected data and parity bits of a frame
  function automatic logic [9:0] fr(logic [8:0] d, int nb, logic pen, logic podd);
    logic [8:0] m;
    m = 9'h1ff >> (9 - nb);
    fr = {1'b0, d & m};
    if (pen) fr[nb] = ^(d & m) ^ podd;
  endfunction : fr
  task print_verdict;
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // Watchdog
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    print_verdict;
  end
  //////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(`USRT_OFF_CSB, 0, 0);
    chk(q, `USRT_RST_B, "csb reset");
    apb(`USRT_OFF_CSC, 0, 0);
    chk(q, `USRT_RST_C, "csc reset");
    apb(`USRT_OFF_BAUD, 0, 0);
    chk(q, `USRT_RST_BAUD, "baud reset");
    apb(`USRT_OFF_CSA, 0, 0);
    chk(q[5], 1, "empty at reset");
    apb(8'h14, 0, 0);
    chk({se, q[30:0]}, 32'h80000000, "unmapped");
    apb(`USRT_OFF_CSB, 1, 8'hf8);
    gie <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      fmt = $random(seed);
      nb = fmt[2:0] == 7 ? 9 : fmt[2:0] > 3 ? 8 : 5 + fmt[2:0];
      n = nb + fmt[3];
      u_stn.bit_cyc = (fmt[6] ? 8 : 16) * (fmt[7] + 1);
      e = (fmt[5] ? 3 : 1) * u_stn.bit_cyc / 2;
      bcsb = 8'hf8 | {fmt[2], 2'b00};
      da = 9'($random(seed));
      db = 9'($random(seed));
      apb(`USRT_OFF_CSC, 1, {fmt[3], fmt[4], fmt[5], fmt[1:0], 1'b0});
      apb(`USRT_OFF_BAUD, 1, 32'(fmt[7]));
      apb(`USRT_OFF_CSA, 1, {fmt[6], 1'b0} | 8'h40);
      apb(`USRT_OFF_CSB, 1, bcsb | da[8]);
      apb(`USRT_OFF_DATA, 1, da);
      fork
        begin
          u_stn.grab(ga, n, ok, t1);
          u_stn.grab(gb, n, ok2, t2);
        end
        begin
          wait (txd_out === 1'b0);
          apb(`USRT_OFF_CSB, 1, bcsb | db[8]);
          apb(`USRT_OFF_DATA, 1, db);
          apb(`USRT_OFF_CSA, 0, 0);
          chk(q[5], 0, "empty while full");
        end
      join
      chk(ok && ok2, 1, "frame shape");
      chk(ga, fr(da, nb, fmt[3], fmt[4]), "frame a");
      chk(gb, fr(db, nb, fmt[3], fmt[4]), "frame b");
      chk(t2 >= e - 2 && t2 <= e + 2, 1, "stop gap");
      for (int t = 0; t < 400 && it !== 1'b1; t++) @(posedge pclk);
      chk(it, 1, "complete irq");
      chk(txd_out, 1, "idle level");
      if (i[0]) begin
        ack <= 1'b1;
        @(posedge pclk);
        ack <= 1'b0;
      end else apb(`USRT_OFF_CSA, 1, {fmt[6], 1'b0} | 8'h40);
      apb(`USRT_OFF_CSA, 0, 0);
      chk(q[6], 0, "complete cleared");
      chk(iu, 1, "empty irq");
      rv = 9'($random(seed));
      u_stn.send(fr(rv, nb, fmt[3], fmt[4]), n, fmt[5] ? 2 : 1);
      for (int t = 0; t < 400 && ir !== 1'b1; t++) @(posedge pclk);
      chk(ir, 1, "rx irq");
      apb(`USRT_OFF_CSB, 0, 0);
      if (nb == 9) chk(q[1], rv[8], "rx ninth");
      apb(`USRT_OFF_DATA, 0, 0);
      chk(q, fr(rv, nb, 0, 0) & 10'hff, "rx data");
      apb(`USRT_OFF_CSA, 0, 0);
      chk(q[7], 0, "rx flag read");
    end
    // Synchronous frame clocked by the serial clock pin
    apb(`USRT_OFF_CSC, 1, 8'h46);
    apb(`USRT_OFF_CSB, 1, 8'hf8);
    apb(`USRT_OFF_DATA, 1, 8'h3c);
    for (int i = 0; i < 12; i++) begin
      repeat (4) @(posedge pclk);
      serial_clock_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      serial_clock_pin <= 1'b0;
      if (i < 10) ga[i] = txd_out;
    end
    chk(ga, 10'h278, "sync frame");
    apb(`USRT_OFF_CSC, 1, 8'h06);
    n = 8;
    apb(`USRT_OFF_DATA, 1, 8'ha5);
    apb(`USRT_OFF_CSB, 1, 8'h10);
    u_stn.grab(ga, n, ok, t1);
    chk(ok, 1, "disable waits");
    chk(ga, 10'h0a5, "disable frame");
    repeat (64) @(posedge pclk);
    chk(txd_oe, 0, "pin released");
    print_verdict;
  end
endmodule : testbench
